// ### verilog/xorpq_desc_engine.sv
/*
 Chain-descriptor engine for dual-XOR and three-source P+Q transfers.
 Assumes Avalon-MM register access and a memory port whose read data
 stand in the cycle that waitrequest is low; one clock, sync reset.
*/
// Behaviour
// - Dual-XOR layout used only when control word bit 27 is set.
// - Dual-XOR extends the eight-word layout to nine words with new register meanings.
// - Dual-XOR word order: link, src1, src2, horiz, diag, hdest, count, ctrl, ddest.
// - Each descriptor word lands in its own working register unchanged.
// - Zero link word ends the chain, else it is the next address.
// - Low five link bits are ignored when forming the fetch address.
// - Horizontal result goes to horizontal destination, diagonal to diagonal.
// - Loaded source and destination addresses are driven onto the memory bus.
// - Byte count word sets bytes processed and loads the count register.
// - Control word configures one operation, loaded into control register.
// - Any source alignment; software matches destination offsets modulo 16.
// - P+Q second word is fill data for a block fill, else source one.
// - Multiplier word bytes 0..2 serve sources one..three; byte 3 unused.
// - Source multiplier byte drives the GF multiplier while that source is read.
// - P+Q addresses accepted at any byte alignment.
`timescale 1ns/1ps
module xorpq_desc_engine (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [xorpq_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [xorpq_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_mem_read,
  output logic o_mem_write,
  output logic [xorpq_pkg::ADDR_W-1:0] o_mem_address,
  output logic [xorpq_pkg::DATA_W-1:0] o_mem_writedata,
  input wire logic [xorpq_pkg::DATA_W-1:0] i_mem_readdata,
  input wire logic i_mem_waitrequest,
  output logic [7:0] o_source_multiplier_byte,
  output logic o_gf_active,
  output logic o_busy
);
  import xorpq_pkg::*;

  state_t state;
  state_t resume_state;
  logic [DATA_W-1:0] work [DESC_WORDS];
  logic [3:0] word_idx;
  logic [2:0] src_idx;
  logic [ADDR_W-1:0] fetch_addr;
  logic [29:0] word_offset;
  logic [29:0] words_left;
  logic [DATA_W-1:0] acc_h;
  logic [DATA_W-1:0] acc_d;
  logic last_drain;
  logic pq_mode;
  logic start_req;
  logic done;
  logic [ADDR_W-1:0] chain_head;
  logic avs_ack;
  logic avs_req;
  logic mem_take;
  logic dual_mode;
  logic fill_mode;
  logic [2:0] src_count;
  logic [3:0] desc_last;
  logic [ADDR_W-1:0] offset_bytes;
  logic [ADDR_W-1:0] src_addr;
  logic [29:0] count_words;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FIFO_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [3:0] work_sel;

  // Decoded from the loaded working registers
  assign dual_mode = work[W_CTRL][DUAL_BIT];
  assign fill_mode = pq_mode && !dual_mode && work[W_CTRL][FILL_BIT];
  assign src_count = dual_mode ? SRC_N_DUAL : (pq_mode ? SRC_N_PQ : SRC_N_PLAIN);
  assign offset_bytes = {word_offset, 2'b00};
  // Sources start at word 1 in every format (words 1..2, 1..3 or 1..4); no alignment is imposed
  assign src_addr = work[4'(src_idx) + W_SRC1] + offset_bytes;
  // Partial trailing word rounds up to a whole word
  assign count_words = work[W_COUNT][31:WORD_SHIFT] + 30'(|work[W_COUNT][1:0]);
  assign mem_take = !i_mem_waitrequest;

  // Ninth word is fetched only once the control word (word 7) shows dual mode
  always_comb begin
    desc_last = BASE_LAST;
    if (word_idx > BASE_LAST && dual_mode) begin
      desc_last = DUAL_LAST;
    end
  end

  // Memory port: descriptor and source reads, result writes from the buffer
  always_comb begin
    o_mem_read = 1'b0;
    o_mem_address = '0;
    case (state)
      ST_DESC: begin
        o_mem_read = 1'b1;
        o_mem_address = fetch_addr + {26'h0, word_idx, 2'b00};
      end
      ST_SRC: begin
        // No read on the exit cycle or in fill, so a stalled read is never withdrawn
        o_mem_read = (words_left != '0) && !fill_mode;
        o_mem_address = src_addr;
      end
      ST_DRAIN: begin
        o_mem_address = fifo_out_data[FIFO_W-1:DATA_W];
      end
      default: begin
        o_mem_read = 1'b0;
      end
    endcase
  end
  assign o_mem_write = (state == ST_DRAIN) && fifo_out_valid;
  assign o_mem_writedata = fifo_out_data[DATA_W-1:0];
  assign fifo_out_ready = (state == ST_DRAIN) && mem_take;

  // Multiplier byte follows the source being fetched
  assign o_gf_active = (state == ST_SRC) && pq_mode && !dual_mode && !fill_mode
    && (words_left != '0);
  assign o_source_multiplier_byte = o_gf_active ?
    work[W_SRC4][{src_idx[1:0], 3'b000} +: 8] : 8'h00;

  // Result entries carry their own destination address
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    if (state == ST_PUSH_H) begin
      fifo_in_valid = 1'b1;
      fifo_in_data = {work[W_DEST] + offset_bytes, acc_h};
    end else if (state == ST_PUSH_D) begin
      fifo_in_valid = 1'b1;
      fifo_in_data = {work[W_DDEST] + offset_bytes, acc_d};
    end
  end

  result_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // Sequencer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      resume_state <= ST_IDLE;
      word_idx <= '0;
      src_idx <= '0;
      fetch_addr <= '0;
      word_offset <= '0;
      words_left <= '0;
      last_drain <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            fetch_addr <= chain_head & LINK_MASK;
            word_idx <= '0;
            state <= ST_DESC;
          end
        end
        ST_DESC: begin
          if (mem_take) begin
            word_idx <= word_idx + 4'h1;
            if (word_idx == BASE_LAST && i_mem_readdata[DUAL_BIT]) begin
              state <= ST_DESC;
            end else if (word_idx >= desc_last) begin
              // All words held before any data moves
              word_offset <= '0;
              words_left <= count_words;
              src_idx <= '0;
              last_drain <= 1'b0;
              state <= ST_SRC;
            end
          end
        end
        ST_SRC: begin
          if (words_left == '0) begin
            last_drain <= 1'b1;
            state <= ST_DRAIN;
          end else if (fill_mode) begin
            state <= ST_PUSH_H;
          end else if (mem_take) begin
            if (src_idx == src_count - 3'h1) begin
              src_idx <= '0;
              state <= ST_PUSH_H;
            end else begin
              src_idx <= src_idx + 3'h1;
            end
          end
        end
        ST_PUSH_H, ST_PUSH_D: begin
          // Full buffer: write results out, then retry this push
          if (!fifo_in_ready) begin
            resume_state <= state;
            state <= ST_DRAIN;
          end else if (state == ST_PUSH_H && dual_mode) begin
            state <= ST_PUSH_D;
          end else begin
            word_offset <= word_offset + 30'h1;
            words_left <= words_left - 30'h1;
            state <= ST_SRC;
          end
        end
        ST_DRAIN: begin
          if (!fifo_out_valid) begin
            state <= last_drain ? ST_NEXT : resume_state;
          end
        end
        ST_NEXT: begin
          if (work[W_LINK] == '0) begin
            state <= ST_IDLE;
          end else begin
            fetch_addr <= work[W_LINK] & LINK_MASK;
            word_idx <= '0;
            state <= ST_DESC;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Working registers take each word verbatim
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < DESC_WORDS; i++) begin
        work[i] <= '0;
      end
    end else if (state == ST_DESC && mem_take) begin
      work[word_idx] <= i_mem_readdata;
      if (word_idx == BASE_LAST && !i_mem_readdata[DUAL_BIT]) begin
        work[W_DDEST] <= '0;
      end
    end
  end

  // Accumulators: shared sources feed both results in dual mode
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_h <= '0;
      acc_d <= '0;
    end else if (state == ST_SRC && words_left != '0) begin
      if (fill_mode) begin
        acc_h <= work[W_SRC1];
      end else if (mem_take) begin
        if (!dual_mode || src_idx != SRC_DIAG) begin
          acc_h <= (src_idx == '0) ? i_mem_readdata : acc_h ^ i_mem_readdata;
        end
        if (dual_mode && src_idx != SRC_HORIZ) begin
          acc_d <= (src_idx == '0) ? i_mem_readdata : acc_d ^ i_mem_readdata;
        end
      end
    end
  end

  // Register slave: one wait cycle, answer at the second edge
  assign avs_req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = avs_req && !avs_ack;
  assign work_sel = 4'(i_avs_address[7:2] - REG_WORK_BASE[7:2]);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      avs_ack <= 1'b0;
    end else begin
      avs_ack <= avs_req && !avs_ack;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && !avs_ack) begin
      if (i_avs_address == REG_CTRL) begin
        o_avs_readdata <= {30'h0, pq_mode, 1'b0};
      end else if (i_avs_address == REG_HEAD) begin
        o_avs_readdata <= chain_head;
      end else if (i_avs_address == REG_STATUS) begin
        o_avs_readdata <= {30'h0, done, o_busy};
      end else if (i_avs_address >= REG_WORK_BASE && i_avs_address <= REG_WORK_LAST
                   && i_avs_address[1:0] == 2'b00) begin
        o_avs_readdata <= work[work_sel];
      end else begin
        o_avs_readdata <= UNMAPPED_DATA;
      end
    end
  end

  // Writes land on the accepting edge; start ignored while busy
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      chain_head <= '0;
      pq_mode <= 1'b0;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (i_avs_write && avs_ack) begin
        if (i_avs_address == REG_HEAD) begin
          for (int b = 0; b < 4; b++) begin
            if (i_avs_byteenable[b]) begin
              chain_head[b*8 +: 8] <= i_avs_writedata[b*8 +: 8];
            end
          end
        end else if (i_avs_address == REG_CTRL && i_avs_byteenable[0] && !o_busy) begin
          pq_mode <= i_avs_writedata[CTRL_PQ_BIT];
          start_req <= i_avs_writedata[CTRL_START_BIT];
        end
      end
    end
  end

  // Done stays set until the next start
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      done <= 1'b0;
    end else if (state == ST_NEXT && work[W_LINK] == '0) begin
      done <= 1'b1;
    end else if (start_req) begin
      done <= 1'b0;
    end
  end

  assign o_busy = (state != ST_IDLE) || start_req;
endmodule

// ### verilog/xorpq_pkg.sv
/*
 Constants shared by the descriptor engine and its result buffer.
 Assumes one 100 MHz clock and byte addressing on both buses.
*/
package xorpq_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int DESC_WORDS = 9;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = ADDR_W + DATA_W;
  // Descriptor word positions
  localparam logic [3:0] W_LINK = 4'h0;
  localparam logic [3:0] W_SRC1 = 4'h1;
  localparam logic [3:0] W_SRC2 = 4'h2;
  localparam logic [3:0] W_SRC3 = 4'h3;
  localparam logic [3:0] W_SRC4 = 4'h4;
  localparam logic [3:0] W_DEST = 4'h5;
  localparam logic [3:0] W_COUNT = 4'h6;
  localparam logic [3:0] W_CTRL = 4'h7;
  localparam logic [3:0] W_DDEST = 4'h8;
  localparam logic [3:0] BASE_LAST = 4'h7;
  localparam logic [3:0] DUAL_LAST = 4'h8;
  // Control word fields
  localparam int DUAL_BIT = 27;
  localparam int FILL_BIT = 0;
  localparam logic [31:0] LINK_MASK = 32'hffff_ffe0;
  // Sources per format
  localparam logic [2:0] SRC_N_DUAL = 3'h4;
  localparam logic [2:0] SRC_N_PQ = 3'h3;
  localparam logic [2:0] SRC_N_PLAIN = 3'h2;
  localparam logic [2:0] SRC_HORIZ = 3'h2;
  localparam logic [2:0] SRC_DIAG = 3'h3;
  localparam int WORD_SHIFT = 2;
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HEAD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_WORK_BASE = 8'h10;
  localparam logic [7:0] REG_WORK_LAST = 8'h30;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PQ_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DESC, ST_SRC, ST_PUSH_H, ST_PUSH_D, ST_DRAIN, ST_NEXT
  } state_t;
endpackage

// ### verilog/result_fifo.sv
/*
 Result buffer: synchronous FIFO of address and data pairs.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (PTR_W+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers wrap because depth is a power of two
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### sim/local_mem_model.sv
/* Local memory model on the engine's memory port.
 Assumes word storage loaded by the bench; optional stall every other cycle. */
`timescale 1ns/1ps
module local_mem_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_mem_read,
  input wire logic i_mem_write,
  input wire logic [31:0] i_mem_address,
  input wire logic [31:0] i_mem_writedata,
  output logic [31:0] o_mem_readdata,
  output logic o_mem_waitrequest
);
  logic [31:0] mem [0:1023];
  logic [31:0] last = 32'h0;
  logic phase = 1'b0;
  wire logic req = i_mem_read | i_mem_write;
  wire logic [9:0] idx = i_mem_address[11:2];
  assign o_mem_waitrequest = req & i_slow & ~phase;
  // Stale data inverted so it never passes for an answer
  assign o_mem_readdata = (i_mem_read & ~o_mem_waitrequest) ? mem[idx] : ~last;
  always @(posedge i_clk) begin
    phase <= req ? ~phase : 1'b0;
    if (i_mem_read & ~o_mem_waitrequest) last <= mem[idx];
    if (i_mem_write & ~o_mem_waitrequest) mem[idx] <= i_mem_writedata;
  end
endmodule

// ### sim/xorpq_desc_engine_sva.sv
/* Port checker for the descriptor engine.
 Assumes it is bound to the engine top; one clock, sync reset. */
`timescale 1ns/1ps
module xorpq_desc_engine_sva (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_mem_read,
  input wire logic o_mem_write,
  input wire logic [31:0] o_mem_address,
  input wire logic [31:0] o_mem_writedata,
  input wire logic i_mem_waitrequest,
  input wire logic [7:0] o_source_multiplier_byte,
  input wire logic o_gf_active,
  input wire logic o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_avs_wait_once: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("register bus waited twice");
  chk_avs_idle_ready: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest without request");
  chk_mem_addr_hold: assert property ((o_mem_read | o_mem_write) && i_mem_waitrequest
    |=> $stable(o_mem_address) && $stable({o_mem_read, o_mem_write}))
    else $error("memory request changed while stalled");
  chk_mem_data_hold: assert property (o_mem_write && i_mem_waitrequest
    |=> $stable(o_mem_writedata)) else $error("write data changed while stalled");
  chk_mem_excl: assert property (!(o_mem_read && o_mem_write))
    else $error("memory read and write together");
  chk_idle_quiet: assert property (!o_busy |-> !o_mem_read && !o_mem_write)
    else $error("memory traffic while idle");
  chk_mult_zero: assert property (!o_gf_active |-> o_source_multiplier_byte == 8'h00)
    else $error("multiplier byte outside source read");
  chk_mult_hold: assert property (o_gf_active && i_mem_waitrequest
    |=> o_gf_active && $stable(o_source_multiplier_byte)) else $error("multiplier moved");
  chk_gf_read: assert property (o_gf_active |-> o_mem_read && o_busy)
    else $error("multiplier active without read");
endmodule

// ### sim/xorpq_desc_engine_test.sv
/* Self-checking bench for the descriptor engine.
 Assumes the local memory model and the port checker beside it. */
`timescale 1ns/1ps
module xorpq_desc_engine_test;
  import xorpq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, maddr, mwd, mrdata;
  logic wq, mrd, mwr, mwait, gf, busy;
  logic [7:0] mult;
  int err_count = 0;
  int n_tests = 0;
  int gf_seen = 0;
  always #5 clk = ~clk;
  xorpq_desc_engine dut_u (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wq), .o_mem_read(mrd), .o_mem_write(mwr), .o_mem_address(maddr),
    .o_mem_writedata(mwd), .i_mem_readdata(mrdata), .i_mem_waitrequest(mwait),
    .o_source_multiplier_byte(mult), .o_gf_active(gf), .o_busy(busy));
  local_mem_model mem_u (.i_clk(clk), .i_slow(slow), .i_mem_read(mrd), .i_mem_write(mwr),
    .i_mem_address(maddr), .i_mem_writedata(mwd), .o_mem_readdata(mrdata),
    .o_mem_waitrequest(mwait));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Request held up to the edge that samples waitrequest low
  task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] get(input logic [31:0] ba);
    return mem_u.mem[ba[11:2]];
  endfunction
  task automatic desc(input logic [31:0] ba, input logic [31:0] w [9]);
    for (int i = 0; i < 9; i++) mem_u.mem[ba[11:2] + i] = w[i];
  endtask
  task automatic run(input logic pq, input logic [31:0] head);
    logic [31:0] q;
    int n;
    avs(1'b1, REG_HEAD, head, q);
    avs(1'b1, REG_CTRL, {30'h0, pq, 1'b1}, q);
    // Start and mode change refused while busy
    avs(1'b1, REG_CTRL, {30'h0, !pq, 1'b1}, q);
    avs(1'b0, REG_CTRL, 32'h0, q);
    check(q, {30'h0, pq, 1'b0});
    n = 0;
    do begin
      avs(1'b0, REG_STATUS, 32'h0, q);
      n++;
    end while (q[STAT_DONE_BIT] !== 1'b1 && n < 3000);
    check(q, 32'h2);
  endtask
  always @(negedge clk) begin
    if (gf === 1'b1 && mrd === 1'b1 && mwait === 1'b0) begin
      gf_seen++;
      check({24'h0, mult}, {30'h0, maddr[7:6]} + 32'h1);
    end
  end
  task automatic t_regs;
    logic [31:0] q;
    avs(1'b0, REG_STATUS, 32'h0, q);
    check(q, 32'h0);
    avs(1'b0, 8'hfc, 32'h0, q);
    check(q, 32'h0);
  endtask
  task automatic t_plain;
    logic [31:0] q;
    mem_u.mem[32'h5c0 >> 2] = 32'hdead_beef;
    desc(32'h600, '{0, 'h200, 'h240, 'h280, 'h2c0, 'h580, 4, 0, 'h5c0});
    run(1'b0, 32'h600);
    check(get(32'h580), 32'h0300_0000);
    check(get(32'h5c0), 32'hdead_beef);
    avs(1'b0, 8'h30, 32'h0, q);
    check(q, 32'h0);
  endtask
  // Seventeen words give 34 results: buffer fills under a stalling memory
  task automatic t_dual;
    logic [31:0] q;
    slow <= 1'b1;
    mem_u.mem[32'h3c0 >> 2] = 32'hdead_beef;
    mem_u.mem[32'h3e0 >> 2] = 32'hdead_beef;
    desc(32'h100, '{'h19f, 'h200, 'h240, 'h280, 'h2c0, 'h704, 68, 1 << 27, 'h784});
    desc(32'h180, '{0, 'h200, 'h240, 'h280, 'h2c0, 'h3c0, 0, 1 << 27, 'h3e0});
    run(1'b0, 32'h100);
    for (int k = 0; k < 16; k++) begin
      check(get(32'h704 + 4 * k), k);
      check(get(32'h784 + 4 * k), 32'h0700_0000 | k);
    end
    check(get(32'h744), 32'h0500_0000);
    check(get(32'h7c4), 32'h0400_0000);
    check(get(32'h3c0), 32'hdead_beef);
    check(get(32'h3e0), 32'hdead_beef);
    avs(1'b0, 8'h28, 32'h0, q);
    check(q, 32'h0);
    avs(1'b0, 8'h2c, 32'h0, q);
    check(q, 32'h0800_0000);
    avs(1'b1, 8'h30, 32'h1234_5678, q);
    avs(1'b0, 8'h30, 32'h0, q);
    check(q, 32'h3e0);
    slow <= 1'b0;
  endtask
  task automatic t_pq;
    desc(32'h400, '{'h420, 'h201, 'h240, 'h280, 'hff03_0201, 'h500, 8, 0, 0});
    desc(32'h420, '{0, 'h5a5a_1234, 'h240, 'h280, 'h0003_0201, 'h540, 8, 1, 0});
    run(1'b1, 32'h400);
    check(get(32'h500), 32'h0);
    check(get(32'h504), 32'h1);
    check(get(32'h540), 32'h5a5a_1234);
    check(get(32'h544), 32'h5a5a_1234);
    check(gf_seen, 6);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int r = 0; r < 5; r++)
      for (int k = 0; k < 16; k++) mem_u.mem[32'h80 + 16 * r + k] = ((r + 1) << 24) | k;
    t_regs;
    t_plain;
    t_dual;
    t_pq;
    results;
  end
  // Whole run needs well under this span
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    results;
  end
endmodule
bind xorpq_desc_engine xorpq_desc_engine_sva chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_mem_read(o_mem_read), .o_mem_write(o_mem_write), .o_mem_address(o_mem_address),
  .o_mem_writedata(o_mem_writedata), .i_mem_waitrequest(i_mem_waitrequest),
  .o_source_multiplier_byte(o_source_multiplier_byte), .o_gf_active(o_gf_active),
  .o_busy(o_busy));
